// file: inc/fcm_map.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef FCM_MAP_SVH
`define FCM_MAP_SVH
`define FCM_CHANNELS        72
`define FCM_LANE_W          18
`define FCM_LANES           4
`define FCM_MODE_W          3
`define FCM_TRACE_DEPTH     64
`define FCM_TRACE_AW        6
`define FCM_TRACE_W         192
`define FCM_TRACE_CNT_W     29
`define FCM_FAIL_CNT_W      31
`define FCM_CAP_BASE_LOG2   31
`define FCM_CLK_PERIOD_NS   10
`define FCM_CNT_PERIOD_NS   50
`define FCM_CNT_TICK_CYC    ((`FCM_CNT_PERIOD_NS)/(`FCM_CLK_PERIOD_NS))
`define FCM_REG_CTRL        8'h00
`define FCM_REG_MODES       8'h04
`define FCM_REG_ADDR_SEL    8'h08
`define FCM_REG_TRC_TARGET  8'h0C
`define FCM_REG_STATUS      8'h10
`define FCM_REG_TRC_COUNT   8'h14
`define FCM_REG_CNT_TARGET  8'h18
`define FCM_REG_ROW_FAILS   8'h1C
`define FCM_REG_COL_FAILS   8'h20
`define FCM_REG_TRC_INDEX   8'h24
`define FCM_REG_TRC_DATA0   8'h28
`define FCM_REG_TRC_DATA5   8'h3C
`define FCM_CTRL_RUN        0
`define FCM_CTRL_PHYS       1
`define FCM_CTRL_ARM        2
`define FCM_CTRL_FAIL_ONLY  4
`define FCM_CTRL_SRC_FAIL   5
`define FCM_CTRL_RST        32'h0000_0000
`define FCM_MODES_RST       12'h000
`define FCM_ADDR_SEL_RST    32'hFFFF_FFFF
`endif

// file: inc/fcm_pkg.sv
// Types shared by the fail capture files
`include "fcm_map.svh"
package fcm_pkg;
  typedef enum logic [2:0] {
    fcm_off, fcm_all, fcm_exp0, fcm_exp1, fcm_mark_a, fcm_mark_b, fcm_mask
  } fcm_mode_e;

  typedef struct packed {
    logic                     valid;
    logic [`FCM_CHANNELS-1:0] fail;
    logic [`FCM_CHANNELS-1:0] exp_val;
    logic                     mark_a;
    logic                     mark_b;
  } fcm_cmp_s;

  typedef struct packed {
    logic [15:0] row;
    logic [15:0] col;
    logic [15:0] phys_row;
    logic [15:0] phys_col;
  } fcm_addr_s;

  typedef struct packed {
    logic [9:0]  step;
    logic [19:0] ctrl;
    logic [3:0]  ts;
    logic [17:0] area_inv;
    logic [35:0] dgen;
  } fcm_ctx_s;

  typedef struct packed {
    logic [31:0]              fail_addr;
    fcm_ctx_s                 ctx;
    logic [`FCM_CHANNELS-1:0] fail;
  } fcm_trace_s;
endpackage

// file: hdl/fcm_trace_ram.sv
// Trace history memory with registered read port
`timescale 1ns/1ns
module fcm_trace_ram #(
  parameter int W  = 192,
  parameter int D  = 64,
  parameter int AW = 6
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  // Write side
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  // Read side
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem [D];
  logic [W-1:0] rdata_ff;

  // Storage has no reset, only the read register does
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read data always from a flip-flop
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;
endmodule // fcm_trace_ram

// file: hdl/fcm_capture_lane.sv
// One group of channels running under a single capture mode
`timescale 1ns/1ns
module fcm_capture_lane
  import fcm_pkg::*;
#(
  parameter int W = 18
) (
  // Mode of this group
  input  fcm_mode_e        mode_i,
  // Compare results of this cycle
  input  wire logic [W-1:0] fail_i,
  input  wire logic [W-1:0] exp_i,
  input  wire logic         mark_a_i,
  input  wire logic         mark_b_i,
  // Array read data for mask generation
  input  wire logic [W-1:0] rdata_i,
  // Bits to store and care mask
  output logic      [W-1:0] store_o,
  output logic      [W-1:0] mask_o
);
  // Gate failures by mode; mask mode never stores
  always_comb begin
    store_o = '0;
    mask_o  = '1;
    unique case (mode_i)
      fcm_off:    store_o = '0;
      fcm_all:    store_o = fail_i;
      fcm_exp0:   store_o = fail_i & ~exp_i;
      fcm_exp1:   store_o = fail_i & exp_i;
      fcm_mark_a: store_o = mark_a_i ? fail_i : '0;
      fcm_mark_b: store_o = mark_b_i ? fail_i : '0;
      fcm_mask:   mask_o  = rdata_i;
      default:    store_o = '0; // Code 7 is unused
    endcase
  end
endmodule // fcm_capture_lane

// file: hdl/fcm_top.sv
// Fail capture front end, row/column fail counters and trace memory
// Functional notes
// - Unconditional mode stores every reported failure
// - Modes storing only expected-0 or expected-1 failures
// - Modes storing only when mark bit set
// - Mask mode outputs array as care mask
// - Each 36-channel section takes two modes
// - Storing and mask generation coexist in one run
// - Array address logical or descrambled, configurable
// - Address from preselected row and column lines
// - Count failures at row and column addresses
// - Fail counters advance on a 50 ns rate
// - Trace memory 64x192 plus 29-bit counter
// - Trace entry layout address, step, controls, data
// - Record 64 patterns before count is reached
// - Optionally record only failing patterns
// - Capacity 2 GW for one single-bit device
// - Four-fold capacity with 4-Gbit boards, two-fold for one single-bit device (array address is 32 bits)
// - All parallel devices captured in one cycle
// - At most 72 channels per board
`timescale 1ns/1ns
`include "fcm_map.svh"
module fcm_top
  import fcm_pkg::*;
#(
  parameter int CHANNELS      = `FCM_CHANNELS,
  parameter int BOARD_X4      = 0,
  parameter int DEV_BITS_LOG2 = 0
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // Avalon-MM register slave
  input  wire logic [7:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // Compare results, addresses and context from the pattern side
  input  fcm_cmp_s                 cmp_i,
  input  fcm_addr_s                addr_i,
  input  fcm_ctx_s                 ctx_i,
  // Fail capture array port
  input  wire logic [CHANNELS-1:0] fca_rdata_i,
  output logic      [31:0]         fca_addr_o,
  output logic      [CHANNELS-1:0] fca_bit_we_o,
  output logic                     fca_rd_o,
  output logic      [CHANNELS-1:0] cmp_mask_o
);
  localparam int LW = `FCM_LANE_W;
  localparam int MW = `FCM_MODE_W;
  localparam int CW = `FCM_FAIL_CNT_W;
  localparam int TW = `FCM_TRACE_CNT_W;
  localparam int AW = `FCM_TRACE_AW;
  localparam int TICK_CYC = `FCM_CNT_TICK_CYC;
  localparam int CAP_LOG2 = `FCM_CAP_BASE_LOG2 + 2 * BOARD_X4 - DEV_BITS_LOG2;
  localparam logic [32:0] CAP_ONE = 33'h1 << CAP_LOG2;
  localparam logic [31:0] CAP_MASK = (CAP_LOG2 >= 32) ? 32'hFFFF_FFFF :
                                     CAP_ONE[31:0] - 32'h1;
  // Byte-enable merge of a register write
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
  logic [31:0]         ctrl_ff;
  logic [11:0]         modes_ff;
  logic [31:0]         sel_ff;
  logic [TW-1:0]       trc_target_ff;
  logic [31:0]         cnt_target_ff;
  logic [AW-1:0]       trc_index_ff;
  logic                rd_ack_ff;
  logic [31:0]         rdata_ff;
  logic [CHANNELS-1:0] store_w;
  logic [CHANNELS-1:0] mask_w;
  logic [CHANNELS-1:0] bit_we_ff;
  logic [CHANNELS-1:0] mask_ff;
  logic [31:0]         addr_ff;
  logic                rd_ff;
  logic [2:0]          tick_cnt_ff;
  logic                tick_w;
  logic [2:0]          row_pend_ff;
  logic [2:0]          col_pend_ff;
  logic [CW-1:0]       row_fails_ff;
  logic [CW-1:0]       col_fails_ff;
  logic [TW-1:0]       trc_cnt_ff;
  logic [AW-1:0]       wptr_ff;
  logic [AW:0]         fill_ff;
  logic                armed_ff;
  logic                frozen_ff;
  logic [`FCM_TRACE_W-1:0] trc_rdata;
  fcm_trace_s          trc_entry;
  // Bus strobes
  wire logic wr_w  = avs_write_i;
  wire logic run_w = ctrl_ff[`FCM_CTRL_RUN];
  wire logic act_w = run_w & cmp_i.valid;
  wire logic arm_w = wr_w && (avs_address_i == `FCM_REG_CTRL) &&
                     avs_byteenable_i[0] && avs_writedata_i[`FCM_CTRL_ARM];
  wire logic clr_w = wr_w && ((avs_address_i == `FCM_REG_ROW_FAILS) ||
                              (avs_address_i == `FCM_REG_COL_FAILS));
  // Software-written configuration; arm bit is a pulse, not stored
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_ff       <= `FCM_CTRL_RST;
      modes_ff      <= `FCM_MODES_RST;
      sel_ff        <= `FCM_ADDR_SEL_RST;
      trc_target_ff <= '0;
      cnt_target_ff <= '0;
      trc_index_ff  <= '0;
    end else if (wr_w) begin
      unique case (avs_address_i)
        `FCM_REG_CTRL: begin
          ctrl_ff <= be_merge(ctrl_ff, avs_writedata_i, avs_byteenable_i) &
                     32'h0000_0033;
        end
        `FCM_REG_MODES: begin
          modes_ff <= 12'(be_merge({20'h0, modes_ff}, avs_writedata_i,
                                   avs_byteenable_i));
        end
        `FCM_REG_ADDR_SEL: begin
          sel_ff <= be_merge(sel_ff, avs_writedata_i, avs_byteenable_i);
        end
        `FCM_REG_TRC_TARGET: begin
          trc_target_ff <= TW'(be_merge({3'h0, trc_target_ff},
                                        avs_writedata_i, avs_byteenable_i));
        end
        `FCM_REG_CNT_TARGET: begin
          cnt_target_ff <= be_merge(cnt_target_ff, avs_writedata_i,
                                    avs_byteenable_i);
        end
        `FCM_REG_TRC_INDEX: begin
          if (avs_byteenable_i[0]) begin
            trc_index_ff <= avs_writedata_i[AW-1:0];
          end
        end
        default: ;
      endcase
    end
  end
  // Reads take one wait cycle so the answer comes from a register
  assign avs_waitrequest_o = avs_read_i & ~rd_ack_ff;
  assign avs_readdata_o    = rdata_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_ack_ff <= 1'b0;
      rdata_ff  <= '0;
    end else begin
      rd_ack_ff <= avs_read_i & ~rd_ack_ff;
      if (avs_read_i && !rd_ack_ff) begin
        unique case (avs_address_i)
          `FCM_REG_CTRL:       rdata_ff <= ctrl_ff;
          `FCM_REG_MODES:      rdata_ff <= {20'h0, modes_ff};
          `FCM_REG_ADDR_SEL:   rdata_ff <= sel_ff;
          `FCM_REG_TRC_TARGET: rdata_ff <= {3'h0, trc_target_ff};
          `FCM_REG_STATUS:     rdata_ff <= {23'h0, fill_ff, armed_ff,
                                            frozen_ff};
          `FCM_REG_TRC_COUNT:  rdata_ff <= {3'h0, trc_cnt_ff};
          `FCM_REG_CNT_TARGET: rdata_ff <= cnt_target_ff;
          `FCM_REG_ROW_FAILS:  rdata_ff <= {1'b0, row_fails_ff};
          `FCM_REG_COL_FAILS:  rdata_ff <= {1'b0, col_fails_ff};
          `FCM_REG_TRC_INDEX:  rdata_ff <= {26'h0, trc_index_ff};
          default: begin
            if (avs_address_i >= `FCM_REG_TRC_DATA0 &&
                avs_address_i <= `FCM_REG_TRC_DATA5) begin
              rdata_ff <= trc_rdata[32 * (32'(avs_address_i[5:2]) - 32'd10)
                                    +: 32];
            end else begin
              rdata_ff <= '0; // Unmapped reads as zero
            end
          end
        endcase
      end
    end
  end

  // Current row and column, logical or descrambled
  // address source select
  wire logic [15:0] cur_row = ctrl_ff[`FCM_CTRL_PHYS] ? addr_i.phys_row :
                                                        addr_i.row;
  wire logic [15:0] cur_col = ctrl_ff[`FCM_CTRL_PHYS] ? addr_i.phys_col :
                                                        addr_i.col;
  wire logic [31:0] fca_addr_w = {cur_col & sel_ff[31:16],
                                  cur_row & sel_ff[15:0]} & CAP_MASK;
  // One lane per mode: two modes in each 36-channel section
  // four lanes cover 72 channels
  for (genvar g = 0; g < `FCM_LANES; g++) begin : g_lane
    fcm_capture_lane #(.W(LW)) u_lane (
      .mode_i   (fcm_mode_e'(modes_ff[g*MW +: MW])),
      .fail_i   (cmp_i.fail[g*LW +: LW]),
      .exp_i    (cmp_i.exp_val[g*LW +: LW]),
      .mark_a_i (cmp_i.mark_a),
      .mark_b_i (cmp_i.mark_b),
      .rdata_i  (fca_rdata_i[g*LW +: LW]),
      .store_o  (store_w[g*LW +: LW]),
      .mask_o   (mask_w[g*LW +: LW])
    );
  end

  // Array write: all channels of all devices in one cycle
  // single-cycle capture of all channels
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_we_ff <= '0;
      addr_ff   <= '0;
      rd_ff     <= 1'b0;
      mask_ff   <= '1;
    end else begin
      bit_we_ff <= act_w ? store_w : '0;
      addr_ff   <= fca_addr_w;
      rd_ff     <= act_w && (modes_ff[2:0] == 3'(fcm_mask) ||
                             modes_ff[5:3] == 3'(fcm_mask) ||
                             modes_ff[8:6] == 3'(fcm_mask) ||
                             modes_ff[11:9] == 3'(fcm_mask));
      mask_ff   <= mask_w; // Care bits, one cycle behind array data
    end
  end

  assign fca_bit_we_o = bit_we_ff;
  assign fca_addr_o   = addr_ff;
  assign fca_rd_o     = rd_ff;
  assign cmp_mask_o   = mask_ff;
  assign tick_w = (tick_cnt_ff == 3'(TICK_CYC - 1));
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_w ? 3'h0 : tick_cnt_ff + 3'h1;
    end
  end

  // Hits pile up between ticks; a clear on a tick still zeroes the count before the pending hits are added
  // row and column fail counting
  wire logic any_fail = act_w & (|cmp_i.fail);
  wire logic row_hit  = any_fail && (cur_row == cnt_target_ff[15:0]);
  wire logic col_hit  = any_fail && (cur_col == cnt_target_ff[31:16]);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      row_pend_ff  <= '0;
      col_pend_ff  <= '0;
      row_fails_ff <= '0;
      col_fails_ff <= '0;
    end else begin
      row_pend_ff <= tick_w ? {2'h0, row_hit} : row_pend_ff + {2'h0, row_hit};
      col_pend_ff <= tick_w ? {2'h0, col_hit} : col_pend_ff + {2'h0, col_hit};
      if (tick_w) begin
        row_fails_ff <= (clr_w ? '0 : row_fails_ff) + CW'(row_pend_ff);
        col_fails_ff <= (clr_w ? '0 : col_fails_ff) + CW'(col_pend_ff);
      end else if (clr_w) begin
        row_fails_ff <= '0;
        col_fails_ff <= '0;
      end
    end
  end

  // Trace trigger: pattern or fail events counted to the target
  // count source select
  wire logic trc_evt = ctrl_ff[`FCM_CTRL_SRC_FAIL] ? any_fail : act_w;
  wire logic trc_live = armed_ff & ~frozen_ff;
  wire logic trc_hit = trc_live && trc_evt &&
                       (trc_cnt_ff + TW'(1) == trc_target_ff);
  wire logic trc_rec = trc_live && act_w && !trc_hit &&
                       (!ctrl_ff[`FCM_CTRL_FAIL_ONLY] || any_fail);
  assign trc_entry.fail_addr = fca_addr_w;
  assign trc_entry.ctx       = ctx_i;
  assign trc_entry.fail      = cmp_i.fail;
  // circular write, freeze on hit, freeze beats re-arm
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trc_cnt_ff <= '0;
      wptr_ff    <= '0;
      fill_ff    <= '0;
      armed_ff   <= 1'b0;
      frozen_ff  <= 1'b0;
    end else begin
      frozen_ff <= trc_hit | (frozen_ff & ~arm_w);
      if (arm_w) begin
        armed_ff <= 1'b1;
      end
      if (arm_w && !trc_hit) begin
        trc_cnt_ff <= '0;
        wptr_ff    <= '0;
        fill_ff    <= '0;
      end else begin
        if (trc_live && trc_evt) begin
          trc_cnt_ff <= trc_cnt_ff + TW'(1);
        end
        if (trc_rec) begin
          wptr_ff <= wptr_ff + AW'(1);
          if (fill_ff != (AW+1)'(`FCM_TRACE_DEPTH)) begin
            fill_ff <= fill_ff + (AW+1)'(1);
          end
        end
      end
    end
  end

  // Index zero is the oldest entry once the ring is full
  wire logic [AW-1:0] trc_raddr = fill_ff[AW] ? wptr_ff + trc_index_ff :
                                                trc_index_ff;
  fcm_trace_ram #(
    .W  (`FCM_TRACE_W),
    .D  (`FCM_TRACE_DEPTH),
    .AW (AW)
  ) u_trace_ram (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (trc_rec),
    .waddr_i   (wptr_ff),
    .wdata_i   (trc_entry),
    .raddr_i   (trc_raddr),
    .rdata_o   (trc_rdata)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire fcm_mode_e lane0_mode = fcm_mode_e'(modes_ff[2:0]);
  capture_all_a: assert property (
    act_w && lane0_mode == fcm_all && cmp_i.fail[0] |=> fca_bit_we_o[0])
    else $error("failure not stored in unconditional mode");
  expect_gate_a: assert property (
    lane0_mode == fcm_exp0 && cmp_i.exp_val[1] |=> !fca_bit_we_o[1])
    else $error("expected-1 failure stored in expected-0 mode");
  mark_gate_a: assert property (
    lane0_mode == fcm_mark_b && !cmp_i.mark_b |=> !fca_bit_we_o[0])
    else $error("failure stored without mark bit");
  mask_pass_a: assert property (
    fcm_mode_e'(modes_ff[8:6]) == fcm_mask |=>
      cmp_mask_o[36] == $past(fca_rdata_i[36]) && !fca_bit_we_o[36])
    else $error("mask mode output wrong");
  addr_select_a: assert property (
    ctrl_ff[`FCM_CTRL_PHYS] |=>
      fca_addr_o[15:0] == $past(addr_i.phys_row & sel_ff[15:0]))
    else $error("array address not from descrambled row");
  tick_rate_a: assert property (
    tick_w |=> !tick_w [*4] ##1 tick_w)
    else $error("counter rate not every five cycles");
  count_hold_a: assert property (
    !tick_w && !clr_w |=> $stable(row_fails_ff))
    else $error("row counter moved off the slow rate");
  freeze_hold_a: assert property (
    frozen_ff && !arm_w |=> $stable(wptr_ff) && frozen_ff)
    else $error("trace moved while frozen");
  read_wait_a: assert property (
    avs_read_i && !rd_ack_ff |=> !avs_waitrequest_o)
    else $error("read answer not after one wait cycle");
endmodule // fcm_top

// file: dv/fcm_pattern_model.sv
// Pattern source and per-channel compare model feeding the capture inputs
`timescale 1ns/1ns
module fcm_pattern_model
  import fcm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Commands from the bench
  input  wire logic        go_i,
  input  wire logic        cmp_en_i,
  input  wire logic [71:0] dout_i,
  input  wire logic [71:0] exp_i,
  input  wire logic [1:0]  mark_i,
  input  wire logic [15:0] row_i,
  input  wire logic [15:0] col_i,
  // Capture side
  output fcm_cmp_s         cmp_o,
  output fcm_addr_s        addr_o,
  output fcm_ctx_s         ctx_o
);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmp_o <= '0;
      ctx_o <= '0;
    end else if (go_i) begin
      cmp_o.valid   <= 1'b1;
      cmp_o.fail    <= cmp_en_i ? (dout_i ^ exp_i) : '0;
      cmp_o.exp_val <= exp_i;
      cmp_o.mark_a  <= mark_i[0];
      cmp_o.mark_b  <= mark_i[1];
      ctx_o.step    <= ctx_o.step + 10'h001;
      ctx_o.dgen    <= dout_i[35:0];
    end else begin
      // Idle lines toggle so stale values never pass as data
      cmp_o.valid   <= 1'b0;
      cmp_o.fail    <= ~cmp_o.fail;
      cmp_o.exp_val <= ~cmp_o.exp_val;
    end
  end

  // Own descramble table: inverted lines
  always_ff @(posedge clk_i) begin
    addr_o <= {row_i, col_i, ~row_i, ~col_i};
  end
endmodule // fcm_pattern_model

// file: dv/fail_capture_memory_test.sv
// Self-checking bench for the fail capture block
`timescale 1ns/1ns
`include "fcm_map.svh"
module fail_capture_memory_test
  import fcm_pkg::*;
;
  logic clk_i, sys_rst_i, go, avs_read_i, avs_write_i, cmp_en;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic        avs_waitrequest_o, fca_rd_o;
  logic [71:0] dout, exp_r, fca_rdata_i, fca_bit_we_o, cmp_mask_o;
  logic [15:0] row, col;
  logic [31:0] fca_addr_o;
  logic [9:0]  tbl;
  fcm_cmp_s    cmp;
  fcm_addr_s   adr;
  fcm_ctx_s    ctx;
  int mismatches, checks, m;

  fcm_pattern_model fcm_pattern_model_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .go_i(go), .cmp_en_i(cmp_en), .dout_i(dout),
    .exp_i(exp_r), .mark_i(2'b01), .row_i(row), .col_i(col),
    .cmp_o(cmp), .addr_o(adr), .ctx_o(ctx));

  fcm_top fcm_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .cmp_i(cmp), .addr_i(adr),
    .ctx_i(ctx), .fca_rdata_i(fca_rdata_i), .fca_addr_o(fca_addr_o),
    .fca_bit_we_o(fca_bit_we_o), .fca_rd_o(fca_rd_o),
    .cmp_mask_o(cmp_mask_o));

  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Compare and count
  task chk(input logic [71:0] g, input logic [71:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  // One pattern cycle toward the compare model
  task pat(input logic [71:0] d, input logic [15:0] r, input logic [15:0] c);
    @(posedge clk_i);
    go   <= 1'b1;
    dout <= d;
    row  <= r;
    col  <= c;
  endtask

  // Single pattern, then look two edges later
  task one(input logic [71:0] d, input logic [15:0] r, input logic [15:0] c);
    pat(d, r, c);
    @(posedge clk_i) go <= 1'b0;
    @(posedge clk_i) #1;
  endtask

  // Read trace word 0 of one entry; index read register needs 2 cycles
  task trc_word(input logic [5:0] idx, input logic [31:0] e);
    bus(1'b1, `FCM_REG_TRC_INDEX, {26'h0, idx});
    repeat (2) @(posedge clk_i);
    bus(1'b0, `FCM_REG_TRC_DATA0, 32'h0);
    chk(q, e); // fail bits in low word
  endtask

  // Arm, stream n patterns (odd ones fail if sel), check freeze and ends
  task trc(input logic [31:0] ctl, input logic [31:0] tgt, input int n,
           input logic sel, input logic [31:0] st, input logic [5:0] li,
           input logic [31:0] e0, input logic [31:0] el);
    int i;
    bus(1'b1, `FCM_REG_TRC_TARGET, tgt);
    bus(1'b1, `FCM_REG_CTRL, ctl);
    for (i = 1; i <= n; i++) pat((sel && !i[0]) ? 72'h0 : 72'(i), 16'h9, 16'h9);
    @(posedge clk_i) go <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b0, `FCM_REG_STATUS, 32'h0);
    chk(q & 32'h0000_01FD, st); // frozen with fill count
    trc_word(6'h00, e0); // oldest kept
    trc_word(li, el); // last recorded
  endtask

  // Verdict, reached from the main flow or the watchdog
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end

  // Main sequence
  initial begin
    {go, avs_read_i, avs_write_i} = '0;
    {avs_address_i, avs_writedata_i, row, col} = '0;
    dout = 72'h0;
    cmp_en = 1'b1;
    exp_r = 72'h0;
    fca_rdata_i = {18'h00000, 18'h2AAAA, 36'h0};
    tbl = 10'h0E7;
    sys_rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // Register reset values and an unmapped place
    bus(1'b0, `FCM_REG_MODES, 32'h0);
    chk(q, 72'(`FCM_MODES_RST));
    bus(1'b0, `FCM_REG_ADDR_SEL, 32'h0);
    chk(q, 72'(`FCM_ADDR_SEL_RST));
    bus(1'b1, 8'h40, 32'h1234_5678);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 72'h0);
    // Every storing mode on lane 0, exp1 on lane 1, mask on lane 2
    bus(1'b1, `FCM_REG_CTRL, 32'h0000_0001);
    exp_r <= 72'h00_0000_0000_0008_0002;
    for (m = 1; m < 6; m++) begin
      bus(1'b1, `FCM_REG_MODES, 32'h0000_0198 | 32'(m));
      one(72'h10_0004_0001, 16'h0, 16'h0);
      chk(fca_bit_we_o[1:0], tbl[2*m-2 +: 2]);
      chk(fca_bit_we_o[19:18], 2'b10); // second mode
      chk({fca_rd_o, fca_bit_we_o[36]}, 2'b10); // mask not stored
      chk(cmp_mask_o, {18'h3FFFF, 18'h2AAAA, 36'hF_FFFF_FFFF});
    end
    // Selected address lines, logical then descrambled
    exp_r <= 72'h0;
    bus(1'b1, `FCM_REG_MODES, 32'h0000_0001);
    bus(1'b1, `FCM_REG_ADDR_SEL, 32'h00FF_000F);
    one(72'h1, 16'h1234, 16'hABCD);
    chk(fca_addr_o, 32'h00CD_0004); // line selection
    bus(1'b1, `FCM_REG_CTRL, 32'h0000_0003);
    one(72'h1, 16'h1234, 16'hABCD);
    chk(fca_addr_o, 32'h0032_000B); // descrambled address
    bus(1'b1, `FCM_REG_CTRL, 32'h0000_0001);
    cmp_en <= 1'b0;
    one(72'h1, 16'h0, 16'h0);
    chk(fca_bit_we_o, 72'h0); // disabled compare flags nothing
    // Row and column fail counts; flush earlier hits before clearing
    bus(1'b1, `FCM_REG_CNT_TARGET, 32'h0007_0005);
    cmp_en <= 1'b1;
    repeat (12) @(posedge clk_i);
    bus(1'b1, `FCM_REG_ROW_FAILS, 32'h0);
    repeat (6) @(posedge clk_i);
    pat(72'h1, 16'h5, 16'h7);
    pat(72'h3, 16'h5, 16'h7);
    pat(72'h1, 16'h5, 16'h1);
    pat(72'h1, 16'h6, 16'h7);
    pat(72'h0, 16'h5, 16'h7);
    @(posedge clk_i) go <= 1'b0;
    repeat (12) @(posedge clk_i);
    bus(1'b0, `FCM_REG_ROW_FAILS, 32'h0);
    chk(q, 72'h3); // row count
    bus(1'b0, `FCM_REG_COL_FAILS, 32'h0);
    chk(q, 72'h3); // column count
    bus(1'b1, `FCM_REG_COL_FAILS, 32'h0);
    repeat (12) @(posedge clk_i);
    bus(1'b0, `FCM_REG_ROW_FAILS, 32'h0);
    chk(q, 72'h0); // cleared
    // Pattern count trace, then fail-only trace on a fail count
    trc(32'h0000_0005, 32'd70, 73, 1'b0, 32'h101, 6'h3F, 32'd6, 32'd69);
    trc(32'h0000_0035, 32'd5, 12, 1'b1, 32'h011, 6'h03, 32'd1, 32'd7);
    wrap_up;
  end
endmodule // fail_capture_memory_test
